//--- design/tpwm_cap_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tpwm_cap_if;
   tpwm_pkg::tpwm_edge_t edge_sel;
   logic pulse;
   modport det (input edge_sel, output pulse);
   modport user (output edge_sel, input pulse);
endinterface : tpwm_cap_if
`default_nettype wire

//--- design/tpwm_defines.svh
// What this block does
// - Mode 100 gives PWM on channel one
// - Period is ch0 plus one, width ch1
// - Channel zero toggles once per PWM period
// - Only a channel one write arms transfer
// - Armed values load into shadows at clear
// - Channel one zero gives constant inactive
// - Channel one equal period gives constant active
// - PWM channel one interrupt on match clock
// - Free-run mode interrupts one step after match
// - Mode 101 free-runs once enabled
// - Each channel compares or captures by select
// - Free-run enable inverts both output pins
// - Compare match raises interrupt, inverts pin
// - Free-run compare writes act immediately
// - Capture edge stores count, raises interrupt
// - Overflow after all ones, wrap, continue
// - Wrap sets sticky flag until cleared
// - Prescale field accepted with enable write
`ifndef TPWM_DEFINES_SVH
`define TPWM_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define TPWM_ADDR_CTL_A 4'h0
`define TPWM_ADDR_CTL_B 4'h1
`define TPWM_ADDR_OPTION 4'h2
`define TPWM_ADDR_OUT_CTRL 4'h3
`define TPWM_ADDR_EDGE_CTRL 4'h4
`define TPWM_ADDR_CCR0 4'h5
`define TPWM_ADDR_CCR1 4'h6
`define TPWM_ADDR_COUNT 4'h7

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TPWM_CE_BIT 7
`define TPWM_PRESCALE_MSB 2
`define TPWM_MODE_MSB 2
`define TPWM_WRAP_BIT 0
`define TPWM_CAPSEL0_BIT 4
`define TPWM_CAPSEL1_BIT 5
`define TPWM_OUTEN0_BIT 0
`define TPWM_OUTEN1_BIT 1

// ----------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------
`define TPWM_MODE_PWM 3'h4
`define TPWM_MODE_FREE 3'h5
`define TPWM_CNT_IDLE 16'hffff
`define TPWM_CNT_ZERO 16'h0000
`define TPWM_RST_WORD 16'h0000

`endif

//--- design/tpwm_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
module tpwm_edge_det (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic pin_in,
   tpwm_cap_if.det cap
);
   logic meta_ff;
   logic sync_ff;
   logic last_ff;
   logic pulse_ff;
   logic rise;
   logic fall;

   // Only the second and third stages are looked at; the first may be metastable.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         last_ff <= 1'b0;
      end else begin
         meta_ff <= pin_in;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
      end
   end

   assign rise = sync_ff & ~last_ff;
   assign fall = ~sync_ff & last_ff;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pulse_ff <= 1'b0;
      end else begin
         unique case (cap.edge_sel)
            tpwm_pkg::TPWM_EDGE_NONE: pulse_ff <= 1'b0;
            tpwm_pkg::TPWM_EDGE_RISE: pulse_ff <= rise;
            tpwm_pkg::TPWM_EDGE_FALL: pulse_ff <= fall;
            tpwm_pkg::TPWM_EDGE_BOTH: pulse_ff <= rise | fall;
         endcase
      end
   end

   assign cap.pulse = pulse_ff;
endmodule : tpwm_edge_det
`default_nettype wire

//--- design/tpwm_pkg.sv
`default_nettype none
package tpwm_pkg;
   typedef logic [15:0] tpwm_word_t;
   typedef enum logic [1:0] {
      TPWM_EDGE_NONE,
      TPWM_EDGE_RISE,
      TPWM_EDGE_FALL,
      TPWM_EDGE_BOTH
   } tpwm_edge_t;
endpackage : tpwm_pkg
`default_nettype wire

//--- design/tpwm_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_defines.svh"
module tpwm_timer (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic count_tick,
   output logic [2:0] prescale_select,
   input wire logic capture_in_chan0,
   input wire logic capture_in_chan1,
   output logic timer_out_ch0,
   output logic timer_out_ch1,
   output logic match_irq_ch0,
   output logic match_irq_ch1,
   output logic wrap_irq
);
   // ----------------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------------
   logic count_enable_bit_ff;
   logic [2:0] prescale_ff;
   logic [2:0] op_mode_field_ff;
   logic wrap_flag_ff;
   logic cap_select_ch0_ff;
   logic cap_select_ch1_ff;
   logic [1:0] out_en_ff;
   logic [3:0] edge_ctrl_ff;
   tpwm_pkg::tpwm_word_t cmp_cap_reg_ch0_ff;
   tpwm_pkg::tpwm_word_t cmp_cap_reg_ch1_ff;
   tpwm_pkg::tpwm_word_t shadow_buf_ch0_ff;
   tpwm_pkg::tpwm_word_t shadow_buf_ch1_ff;
   tpwm_pkg::tpwm_word_t cnt_ff;
   logic started_ff;
   logic armed_ff;
   logic lvl0_ff;
   logic lvl1_ff;
   logic [15:0] rdata_ff;
   logic irq0_ff;
   logic irq1_ff;
   logic wrap_irq_ff;
   logic pin0_ff;
   logic pin1_ff;

   // ----------------------------------------------------------------------
   // Next values
   // ----------------------------------------------------------------------
   tpwm_pkg::tpwm_word_t nxt_cnt;
   tpwm_pkg::tpwm_word_t nxt_buf0;
   tpwm_pkg::tpwm_word_t nxt_buf1;
   logic nxt_started;
   logic nxt_lvl0;
   logic nxt_lvl1;
   logic nxt_irq0;
   logic nxt_irq1;
   logic xfer;
   logic pwm_clear;
   logic wrap;

   logic mode_pwm;
   logic mode_free;
   logic wr_ctl_a;
   logic wr_ctl_b;
   logic wr_option;
   logic wr_out_ctrl;
   logic wr_edge;
   logic wr_ccr0;
   logic wr_ccr1;
   logic enable_rise;
   logic step;
   logic cmp0_hit;
   logic cmp1_hit;
   logic cap0_hit;
   logic cap1_hit;

   tpwm_cap_if cap0_if ();
   tpwm_cap_if cap1_if ();

   // ----------------------------------------------------------------------
   // Capture inputs
   // ----------------------------------------------------------------------
   assign cap0_if.edge_sel = tpwm_pkg::tpwm_edge_t'(edge_ctrl_ff[1:0]);
   assign cap1_if.edge_sel = tpwm_pkg::tpwm_edge_t'(edge_ctrl_ff[3:2]);

   tpwm_edge_det u_edge0 (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .pin_in(capture_in_chan0),
      .cap(cap0_if.det)
   );

   tpwm_edge_det u_edge1 (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .pin_in(capture_in_chan1),
      .cap(cap1_if.det)
   );

   // ----------------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------------
   assign mode_pwm = (op_mode_field_ff == `TPWM_MODE_PWM);
   assign mode_free = (op_mode_field_ff == `TPWM_MODE_FREE);
   assign wr_ctl_a = reg_wr && (reg_addr == `TPWM_ADDR_CTL_A);
   assign wr_ctl_b = reg_wr && (reg_addr == `TPWM_ADDR_CTL_B);
   assign wr_option = reg_wr && (reg_addr == `TPWM_ADDR_OPTION);
   assign wr_out_ctrl = reg_wr && (reg_addr == `TPWM_ADDR_OUT_CTRL);
   assign wr_edge = reg_wr && (reg_addr == `TPWM_ADDR_EDGE_CTRL);
   assign wr_ccr0 = reg_wr && (reg_addr == `TPWM_ADDR_CCR0);
   assign wr_ccr1 = reg_wr && (reg_addr == `TPWM_ADDR_CCR1);
   assign enable_rise = wr_ctl_a && reg_wdata[`TPWM_CE_BIT]
                        && !count_enable_bit_ff;
   assign step = count_enable_bit_ff && count_tick && started_ff;

   // Compare looks at the live register, so a write counts at once.
   assign cmp0_hit = step && mode_free && !cap_select_ch0_ff
                     && (cnt_ff == cmp_cap_reg_ch0_ff);
   assign cmp1_hit = step && mode_free && !cap_select_ch1_ff
                     && (cnt_ff == cmp_cap_reg_ch1_ff);
   assign cap0_hit = count_enable_bit_ff && mode_free && cap_select_ch0_ff
                     && cap0_if.pulse;
   assign cap1_hit = count_enable_bit_ff && mode_free && cap_select_ch1_ff
                     && cap1_if.pulse;

   // ----------------------------------------------------------------------
   // Counter and shadow transfer
   // ----------------------------------------------------------------------
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_started = started_ff;
      xfer = 1'b0;
      pwm_clear = 1'b0;
      wrap = 1'b0;
      if (!count_enable_bit_ff) begin
         nxt_cnt = `TPWM_CNT_IDLE;
         nxt_started = 1'b0;
      end else if (count_tick) begin
         if (!started_ff) begin
            nxt_cnt = `TPWM_CNT_ZERO;
            nxt_started = 1'b1;
            xfer = mode_pwm;
         end else if (mode_pwm && (cnt_ff == shadow_buf_ch0_ff)) begin
            nxt_cnt = `TPWM_CNT_ZERO;
            pwm_clear = 1'b1;
            xfer = armed_ff;
         end else begin
            nxt_cnt = cnt_ff + 16'h0001;
            wrap = mode_free && (cnt_ff == `TPWM_CNT_IDLE);
         end
      end
   end

   always_comb begin
      nxt_buf0 = shadow_buf_ch0_ff;
      nxt_buf1 = shadow_buf_ch1_ff;
      if (xfer) begin
         nxt_buf0 = cmp_cap_reg_ch0_ff;
         nxt_buf1 = cmp_cap_reg_ch1_ff;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cnt_ff <= `TPWM_CNT_IDLE;
         started_ff <= 1'b0;
         shadow_buf_ch0_ff <= `TPWM_RST_WORD;
         shadow_buf_ch1_ff <= `TPWM_RST_WORD;
      end else begin
         cnt_ff <= nxt_cnt;
         started_ff <= nxt_started;
         shadow_buf_ch0_ff <= nxt_buf0;
         shadow_buf_ch1_ff <= nxt_buf1;
      end
   end

   // A rewrite before the transfer lands is the caller's hazard; the
   // arming write during a transfer cycle keeps the request for next time.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         armed_ff <= 1'b0;
      end else if (wr_ccr1 && mode_pwm) begin
         armed_ff <= 1'b1;
      end else if (xfer || !count_enable_bit_ff) begin
         armed_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Output levels and interrupts
   // ----------------------------------------------------------------------
   always_comb begin
      nxt_lvl0 = lvl0_ff;
      nxt_lvl1 = lvl1_ff;
      nxt_irq0 = 1'b0;
      nxt_irq1 = 1'b0;
      if (mode_pwm && count_enable_bit_ff && count_tick) begin
         // Channel one compares strictly below the width, so zero never
         // goes active and period plus one never goes inactive.
         nxt_lvl1 = (nxt_cnt < nxt_buf1);
         nxt_irq1 = (nxt_cnt == nxt_buf1);
         if (pwm_clear) begin
            nxt_lvl0 = ~lvl0_ff;
            nxt_irq0 = 1'b1;
         end
      end else if (mode_free) begin
         if (enable_rise) begin
            nxt_lvl0 = ~lvl0_ff;
            nxt_lvl1 = ~lvl1_ff;
         end
         if (cmp0_hit) begin
            nxt_lvl0 = ~lvl0_ff;
         end
         if (cmp1_hit) begin
            nxt_lvl1 = ~lvl1_ff;
         end
         nxt_irq0 = cmp0_hit || cap0_hit;
         nxt_irq1 = cmp1_hit || cap1_hit;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         lvl0_ff <= 1'b0;
         lvl1_ff <= 1'b0;
         pin0_ff <= 1'b0;
         pin1_ff <= 1'b0;
         irq0_ff <= 1'b0;
         irq1_ff <= 1'b0;
         wrap_irq_ff <= 1'b0;
      end else begin
         lvl0_ff <= nxt_lvl0;
         lvl1_ff <= nxt_lvl1;
         pin0_ff <= nxt_lvl0 & out_en_ff[`TPWM_OUTEN0_BIT];
         pin1_ff <= nxt_lvl1 & out_en_ff[`TPWM_OUTEN1_BIT];
         irq0_ff <= nxt_irq0;
         irq1_ff <= nxt_irq1;
         wrap_irq_ff <= wrap;
      end
   end

   // ----------------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         count_enable_bit_ff <= 1'b0;
         prescale_ff <= 3'h0;
      end else if (wr_ctl_a) begin
         count_enable_bit_ff <= reg_wdata[`TPWM_CE_BIT];
         prescale_ff <= reg_wdata[`TPWM_PRESCALE_MSB:0];
      end
   end

   // Mode changes are only meant while stopped; nothing blocks them.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         op_mode_field_ff <= 3'h0;
      end else if (wr_ctl_b) begin
         op_mode_field_ff <= reg_wdata[`TPWM_MODE_MSB:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cap_select_ch0_ff <= 1'b0;
         cap_select_ch1_ff <= 1'b0;
      end else if (wr_option) begin
         cap_select_ch0_ff <= reg_wdata[`TPWM_CAPSEL0_BIT];
         cap_select_ch1_ff <= reg_wdata[`TPWM_CAPSEL1_BIT];
      end
   end

   // A wrap in the clearing cycle wins, so no overflow is ever lost.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         wrap_flag_ff <= 1'b0;
      end else if (wrap) begin
         wrap_flag_ff <= 1'b1;
      end else if (wr_option && !reg_wdata[`TPWM_WRAP_BIT]) begin
         wrap_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         out_en_ff <= 2'h0;
      end else if (wr_out_ctrl) begin
         out_en_ff <= reg_wdata[1:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         edge_ctrl_ff <= 4'h0;
      end else if (wr_edge) begin
         edge_ctrl_ff <= reg_wdata[3:0];
      end
   end

   // Capture beats a software write in the same cycle.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cmp_cap_reg_ch0_ff <= `TPWM_RST_WORD;
      end else if (cap0_hit) begin
         cmp_cap_reg_ch0_ff <= cnt_ff;
      end else if (wr_ccr0) begin
         cmp_cap_reg_ch0_ff <= reg_wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cmp_cap_reg_ch1_ff <= `TPWM_RST_WORD;
      end else if (cap1_hit) begin
         cmp_cap_reg_ch1_ff <= cnt_ff;
      end else if (wr_ccr1) begin
         cmp_cap_reg_ch1_ff <= reg_wdata;
      end
   end

   // ----------------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rdata_ff <= 16'h0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `TPWM_ADDR_CTL_A: rdata_ff <= {8'h00, count_enable_bit_ff,
                                           4'h0, prescale_ff};
            `TPWM_ADDR_CTL_B: rdata_ff <= {13'h0000, op_mode_field_ff};
            `TPWM_ADDR_OPTION: rdata_ff <= {10'h000, cap_select_ch1_ff,
                                            cap_select_ch0_ff, 3'h0,
                                            wrap_flag_ff};
            `TPWM_ADDR_OUT_CTRL: rdata_ff <= {14'h0000, out_en_ff};
            `TPWM_ADDR_EDGE_CTRL: rdata_ff <= {12'h000, edge_ctrl_ff};
            `TPWM_ADDR_CCR0: rdata_ff <= cmp_cap_reg_ch0_ff;
            `TPWM_ADDR_CCR1: rdata_ff <= cmp_cap_reg_ch1_ff;
            `TPWM_ADDR_COUNT: rdata_ff <= cnt_ff;
            default: rdata_ff <= 16'h0000;
         endcase
      end else begin
         rdata_ff <= 16'h0000;
      end
   end

   assign reg_rdata = rdata_ff;
   assign prescale_select = prescale_ff;
   assign timer_out_ch0 = pin0_ff;
   assign timer_out_ch1 = pin1_ff;
   assign match_irq_ch0 = irq0_ff;
   assign match_irq_ch1 = irq1_ff;
   assign wrap_irq = wrap_irq_ff;
endmodule : tpwm_timer
`default_nettype wire

//--- tb/timer_pwm_freerun_modes_bench.sv
`timescale 1ns/1ps
`default_nettype none
module timer_pwm_freerun_modes_bench;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic count_tick = 1'b1;
   logic cap0 = 1'b0;
   logic cap1 = 1'b0;
   logic [15:0] reg_rdata;
   logic [2:0] prescale_select;
   logic out0;
   logic out1;
   logic [2:0] ev;
   int num_errors = 0;
   int total_checks = 0;
   always #50 sys_clk = ~sys_clk;
   tpwm_timer DUT (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .count_tick(count_tick),
      .prescale_select(prescale_select), .capture_in_chan0(cap0),
      .capture_in_chan1(cap1), .timer_out_ch0(out0), .timer_out_ch1(out1),
      .match_irq_ch0(ev[0]), .match_irq_ch1(ev[1]), .wrap_irq(ev[2])
   );
   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Outputs are read in the active region of a clock edge, so they
   // show the settled value of the cycle that just ended.
   task automatic conclude();
      $display("Checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [15:0] exp,
                      input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [15:0] q);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      @(posedge sys_clk);
      q = reg_rdata;
   endtask : rd
   task automatic wait_ev(input int k, input int lim);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
         if (n > lim) begin
            num_errors++;
            $display("Error event %0d expected 1 seen 0", k);
            conclude();
         end
      end while (ev[k] !== 1'b1);
   endtask : wait_ev
   // Counts cycles and active cycles of one full PWM period.
   task automatic period(input int p, input int w);
      int n;
      int hi;
      n = 0;
      hi = 0;
      wait_ev(0, 40);
      do begin
         @(posedge sys_clk);
         n++;
         hi += int'(out1);
      end while (ev[0] !== 1'b1 && n < 40);
      chk("pwm period", 16'(p), 16'(n));
      chk("pwm width", 16'(w), 16'(hi));
   endtask : period
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset();
      logic [15:0] q;
      wr(4'h8, 16'hffff);
      for (int a = 0; a < 9; a++) begin
         rd(4'(a), q);
         chk("reset value", (a == 7) ? 16'hffff : 16'h0000, q);
      end
   endtask : t_reset
   task automatic t_pwm();
      wr(4'h1, 16'h0004);
      wr(4'h3, 16'h0003);
      wr(4'h5, 16'h0004);
      wr(4'h6, 16'h0002);
      wr(4'h0, 16'h0083);
      @(posedge sys_clk);
      chk("prescale", 16'h0003, {13'h0, prescale_select});
      period(5, 2);
      wr(4'h5, 16'h0007);
      period(5, 2);
      wr(4'h6, 16'h0002);
      period(8, 2);
      wr(4'h6, 16'h0008);
      period(8, 8);
      wr(4'h6, 16'h0000);
      period(8, 0);
   endtask : t_pwm
   task automatic t_free();
      logic [15:0] q;
      logic [15:0] c;
      wr(4'h0, 16'h0000);
      rd(4'h7, q);
      chk("idle count", 16'hffff, q);
      wr(4'h1, 16'h0005);
      wr(4'h2, 16'h0020);
      wr(4'h4, 16'h0004);
      wr(4'h5, 16'h0010);
      q = {14'h0, out1, out0};
      wr(4'h0, 16'h0080);
      @(posedge sys_clk);
      chk("start levels", ~q & 16'h0003, {14'h0, out1, out0});
      wait_ev(0, 40);
      chk("compare pin", {15'h0, q[0]}, {15'h0, out0});
      rd(4'h7, c);
      wr(4'h5, c + 16'h0008);
      wait_ev(0, 12);
      rd(4'h7, c);
      cap1 <= 1'b1;
      wait_ev(1, 10);
      rd(4'h6, q);
      chk("capture", 16'h0001, {15'h0, q > c && q < c + 16'h0010});
      cap1 <= 1'b0;
      wait_ev(2, 70000);
      rd(4'h7, q);
      chk("wrap count", 16'h0001, {15'h0, q < 16'h0008});
      rd(4'h2, q);
      chk("wrap flag", 16'h0021, q);
      wr(4'h2, 16'h0020);
      rd(4'h2, q);
      chk("flag clear", 16'h0020, q);
      count_tick <= 1'b0;
      rd(4'h7, q);
      rd(4'h7, c);
      chk("count hold", q, c);
      count_tick <= 1'b1;
   endtask : t_free
   initial begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      t_reset();
      t_pwm();
      t_free();
      conclude();
   end
endmodule : timer_pwm_freerun_modes_bench
`default_nettype wire

//--- tb/tpwm_timer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tpwm_timer_sva (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic count_tick,
   input wire logic [2:0] prescale_select,
   input wire logic capture_in_chan0,
   input wire logic capture_in_chan1,
   input wire logic timer_out_ch0,
   input wire logic timer_out_ch1,
   input wire logic match_irq_ch0,
   input wire logic match_irq_ch1,
   input wire logic wrap_irq
);
   // ---------------------------------------------------------------
   // Helper logic
   // ---------------------------------------------------------------
   // Mode and select bits are not ports, so the checker keeps its own
   // copy of the control words as software writes them.
   logic [15:0] shd_ff [0:4];
   logic en;
   logic oen;
   logic pwm;
   logic frun;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         shd_ff <= '{default: 16'h0000};
      end else if (reg_wr && reg_addr < 4'h5) begin
         shd_ff[reg_addr[2:0]] <= reg_wdata;
      end
   end
   assign en = shd_ff[0][7];
   assign oen = shd_ff[3][1:0] == 2'h3;
   assign pwm = en && oen && shd_ff[1][2:0] == 3'h4;
   assign frun = en && oen && shd_ff[1][2:0] == 3'h5;
   default clocking dc @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   idle_count_a:
      assert property ($past(reg_rd) && $past(reg_addr) == 4'h7 && !en
         && !$past(en) && !$past(en, 2) |-> reg_rdata == 16'hffff)
      else $error("counter not idle while stopped");
   prescale_copy_a:
      assert property (!reg_wr && !$past(reg_wr)
         |-> prescale_select == shd_ff[0][2:0])
      else $error("prescale select differs from written field");
   wrap_pulse_a:
      assert property (wrap_irq |=> !wrap_irq [*8])
      else $error("wrap interrupt longer than one pulse");
   pwm_toggle_a:
      assert property (pwm && match_irq_ch0
         |-> timer_out_ch0 != $past(timer_out_ch0))
      else $error("channel zero did not toggle at period end");
   pwm_fall_a:
      assert property (pwm && $past(pwm)
         && (match_irq_ch1 || $fell(timer_out_ch1))
         |-> match_irq_ch1 && !timer_out_ch1)
      else $error("channel one interrupt not aligned with fall");
   frun_start_a:
      assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[7] && !en
         && oen && shd_ff[1][2:0] == 3'h5 |-> ##[1:2]
         (timer_out_ch0 != $past(timer_out_ch0)
         && timer_out_ch1 != $past(timer_out_ch1)))
      else $error("outputs not inverted at free-run start");
   frun_cmp_a:
      assert property (frun && !shd_ff[2][4] && match_irq_ch0
         |-> timer_out_ch0 != $past(timer_out_ch0))
      else $error("compare match did not invert channel zero");
   capture_irq_a:
      assert property (frun && shd_ff[2][5] && shd_ff[4][3:2] == 2'h1
         && $rose(capture_in_chan1) |-> ##[1:5] match_irq_ch1)
      else $error("capture edge gave no interrupt");
endmodule : tpwm_timer_sva
bind tpwm_timer tpwm_timer_sva u_sva (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .count_tick(count_tick),
   .prescale_select(prescale_select), .capture_in_chan0(capture_in_chan0),
   .capture_in_chan1(capture_in_chan1), .timer_out_ch0(timer_out_ch0),
   .timer_out_ch1(timer_out_ch1), .match_irq_ch0(match_irq_ch0),
   .match_irq_ch1(match_irq_ch1), .wrap_irq(wrap_irq)
);
`default_nettype wire
